/* File: core/dchbh_bus_mux.sv */
module dchbh_bus_mux
  import dchbh_pkg::*;
(
  // Select
  input wire logic granted,
  // Processor side
  input wire dchbh_addr_t cpu_addr,
  input wire dchbh_data_t cpu_wdata,
  input wire logic cpu_drive,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  // Host side
  input wire dchbh_addr_t host_addr,
  input wire dchbh_data_t host_data,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  // Local bus
  output dchbh_addr_t mem_addr,
  output dchbh_data_t mem_wdata,
  output logic mem_rd_n,
  output logic mem_wr_n,
  output logic cpu_addr_oe
);
  //------------------------------------------------------------
  // Local bus steering
  //------------------------------------------------------------
  // Processor lines float once granted
  always_comb
  begin
    cpu_addr_oe = cpu_drive & ~granted;
    if (granted)
    begin
      mem_addr = host_addr;
      mem_wdata = host_data;
      mem_rd_n = host_rd_n;
      mem_wr_n = host_wr_n;
    end
    else
    begin
      // Processor path, idle strobes when floated
      mem_addr = cpu_addr;
      mem_wdata = cpu_wdata;
      mem_rd_n = cpu_rd_n | ~cpu_drive;
      mem_wr_n = cpu_wr_n | ~cpu_drive;
    end
  end
endmodule : dchbh_bus_mux

/* File: core/dchbh_consts.svh */
`ifndef DCHBH_CONSTS_SVH
`define DCHBH_CONSTS_SVH
//------------------------------------------------------------
// What this block does
//------------------------------------------------------------

// Bus widths
`define DCHBH_AW 16
`define DCHBH_DW 8
// Clock rate in Hz
`define DCHBH_CLK_HZ 10000000
// Acknowledge timeout in milliseconds
`define DCHBH_TMO_MS 1000
// Timeout in clock cycles (longest time, rounds down)
`define DCHBH_TMO_CYC ((`DCHBH_CLK_HZ / 1000) * `DCHBH_TMO_MS)
// Reset values
`define DCHBH_ADDR_RST 16'h0000
`define DCHBH_DATA_RST 8'h00
`endif

/* File: core/dchbh_device.sv */
module dchbh_device
  import dchbh_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to host
  dchbh_if.device lnk,
  // Processor core side
  input wire logic hold_inhibit,
  input wire logic instr_done,
  input wire dchbh_addr_t cpu_addr,
  input wire dchbh_data_t cpu_wdata,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  output logic cpu_stall,
  output logic bus_granted,
  // Local memory bus
  output dchbh_addr_t mem_addr,
  output dchbh_data_t mem_wdata,
  output logic mem_rd_n,
  output logic mem_wr_n,
  output logic cpu_addr_oe,
  input wire dchbh_data_t mem_rdata
);
  dchbh_dev_st_t st_q, st_d; // Handover state
  dchbh_data_t rdata_q, rdata_d; // Read data to host
  logic oe_q, oe_d; // Host read data enable
  logic host_reading; // Host read strobe on the granted bus

  //------------------------------------------------------------
  // State decoding
  //------------------------------------------------------------
  // Core held still: bus floated or granted
  function automatic logic dchbh_is_halted(input dchbh_dev_st_t st);
    // Float and grant both keep the core stopped
    return (st == DCHBH_FLOAT) || (st == DCHBH_GRANT);
  endfunction : dchbh_is_halted

  // Bus handed over to the host
  function automatic logic dchbh_is_granted(input dchbh_dev_st_t st);
    // Only the grant state connects the host lines
    return (st == DCHBH_GRANT);
  endfunction : dchbh_is_granted

  // Halt may start: request low, no inhibit
  function automatic logic dchbh_may_halt(input logic req_n, input logic inhibit);
    // Inhibit only matters before the halt starts
    return !req_n && !inhibit;
  endfunction : dchbh_may_halt

  //------------------------------------------------------------
  // Handover steps and limits
  //------------------------------------------------------------
  // Run: core owns the local bus
  // Finish: request seen, instruction completes
  // Float: core stopped, its lines released
  // Grant: host lines and strobes switched in
  // Any state: release returns to run
  // Inhibit looked at only in run
  // Raising inhibit later does not undo a halt
  // Request withdrawn before grant aborts quietly
  // Float lasts one clock: no two drivers
  // Acknowledge drops one clock after release
  // No timeout here: host end keeps its own
  // Core sees stall and must not step
  // Instruction end input may be a level
  // Processor strobes idle while floated
  // Local memory never sees two strobes at once
  // Grant and acknowledge share one register
  // Read data comes one clock after the strobe
  // Host read strobe lasts two clocks
  // Write lands at the end of the strobe clock
  // Reset hands the bus back to the core
  // Memory write data from core while running
  // Host write data only while granted

  //------------------------------------------------------------
  // Handover state machine
  //------------------------------------------------------------
  // Next state
  always_comb
  begin
    // Stay put unless a branch moves on
    st_d = st_q;
    // One branch per handover step
    case (st_q)
      DCHBH_RUN:
        // Core runs its program until asked
        if (dchbh_may_halt(lnk.hold_request_n, hold_inhibit))
          st_d = DCHBH_FINISH;
      DCHBH_FINISH:
        // Request withdrawn: keep running
        if (lnk.hold_request_n)
          st_d = DCHBH_RUN;
        // Instruction boundary: stop and float
        else if (instr_done)
          st_d = DCHBH_FLOAT;
      DCHBH_FLOAT:
        // Bus quiet one clock before the host gets it
        st_d = lnk.hold_request_n ? DCHBH_RUN : DCHBH_GRANT;
      DCHBH_GRANT:
        if (lnk.hold_request_n)
          st_d = DCHBH_RUN;
      // Unused code: back to running
      default:
        st_d = DCHBH_RUN;
    endcase
  end

  // State register
  // Reset returns the core to running with its own bus
  always_ff @(posedge clk or negedge rst_n)
  begin
    // Asynchronous reset: processor owns its bus
    if (!rst_n)
      st_q <= DCHBH_RUN;
    // Advance once per clock
    else
      st_q <= st_d;
  end

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  // resume on release
  // Stall covers float and grant, so the core
  // cannot touch the bus while the host owns it
  assign cpu_stall = dchbh_is_halted(st_q);
  // grant after float
  // Straight from the state register, no glitches
  assign bus_granted = dchbh_is_granted(st_q);
  // acknowledge from grant
  // Same timing as the grant, so the host never
  // sees acknowledge before the switch has moved
  assign lnk.hold_acknowledge_n = ~bus_granted;

  assign host_reading = bus_granted & ~lnk.host_rd_n;

  // Read data capture for host reads
  // Registered, so the host samples one clock later;
  // the host keeps its read strobe for two clocks
  always_comb
  begin
    // Hold last byte between reads
    rdata_d = rdata_q;
    // Drive host data only after a granted read
    oe_d = host_reading;
    // New byte from the local memory
    if (host_reading)
      rdata_d = mem_rdata;
  end

  // Read data registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    // Asynchronous reset: nothing driven toward the host
    if (!rst_n)
    begin
      rdata_q <= `DCHBH_DATA_RST;
      oe_q <= 1'b0;
    end
    // Capture byte and enable each clock
    else
    begin
      rdata_q <= rdata_d;
      oe_q <= oe_d;
    end
  end

  // Read byte toward the host
  assign lnk.dev_rdata = rdata_q;
  // Enable trails the strobe by one clock and may
  // overlap the first clock after the release
  assign lnk.dev_data_oe = oe_q;

  //------------------------------------------------------------
  // Bus switch
  //------------------------------------------------------------
  // core lines float
  dchbh_bus_mux u_mux (
    // Select
    .granted(bus_granted),
    // Processor side, driving only while running
    .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata),
    .cpu_drive(~cpu_stall),
    .cpu_rd_n(cpu_rd_n),
    .cpu_wr_n(cpu_wr_n),
    // Host side
    .host_addr(lnk.host_addr),
    .host_data(lnk.host_data),
    .host_rd_n(lnk.host_rd_n),
    .host_wr_n(lnk.host_wr_n),
    // Local bus
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rd_n(mem_rd_n),
    .mem_wr_n(mem_wr_n),
    .cpu_addr_oe(cpu_addr_oe)
  );
endmodule : dchbh_device

/* File: core/dchbh_host.sv */
module dchbh_host
  import dchbh_pkg::*;
#(
  parameter int unsigned TMO_CYC = `DCHBH_TMO_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to device
  dchbh_if.host lnk,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire dchbh_addr_t req_addr,
  input wire dchbh_data_t req_wdata,
  input wire logic tmo_exempt,
  // User answer
  output logic rsp_valid,
  output dchbh_data_t rsp_rdata,
  output logic malfunction
);
  dchbh_host_st_t st_q, st_d; // Host state
  logic [31:0] cnt_q, cnt_d; // Timeout counter
  logic wr_q, wr_d; // Latched direction
  logic exempt_q, exempt_d; // Timeout exemption
  dchbh_addr_t addr_q, addr_d; // Latched address
  dchbh_data_t wdata_q, wdata_d; // Latched write data
  dchbh_data_t rdata_q, rdata_d; // Read result
  logic rsp_q, rsp_d; // Answer pulse
  logic mal_q, mal_d; // Sticky malfunction

  //------------------------------------------------------------
  // Host transfer sequencer
  //------------------------------------------------------------
  // Next values
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    exempt_d = exempt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    mal_d = mal_q;
    case (st_q)
      // Accept request
      DCHBH_H_IDLE:
        if (req_valid)
        begin
          wr_d = req_write;
          exempt_d = tmo_exempt;
          addr_d = req_addr;
          wdata_d = req_wdata;
          cnt_d = '0;
          st_d = DCHBH_H_WAIT;
        end
      DCHBH_H_WAIT:
        if (!lnk.hold_acknowledge_n)
          st_d = DCHBH_H_XFER;
        else if (!exempt_q && (cnt_q >= TMO_CYC - 1))
        begin
          mal_d = 1'b1;
          st_d = DCHBH_H_REL;
        end
        else
          cnt_d = cnt_q + 32'h00000001;
      // Strobe active; write strobe lasts one cycle, read strobe two
      DCHBH_H_XFER:
        st_d = DCHBH_H_DONE;
      // Capture read data
      DCHBH_H_DONE:
      begin
        rdata_d = wr_q ? rdata_q : lnk.host_data;
        rsp_d = 1'b1;
        st_d = DCHBH_H_REL;
      end
      DCHBH_H_REL:
        if (lnk.hold_acknowledge_n)
          st_d = DCHBH_H_IDLE;
      default:
        st_d = DCHBH_H_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= DCHBH_H_IDLE;
      cnt_q <= 32'h00000000;
      wr_q <= 1'b0;
      exempt_q <= 1'b0;
      addr_q <= `DCHBH_ADDR_RST;
      wdata_q <= `DCHBH_DATA_RST;
      rdata_q <= `DCHBH_DATA_RST;
      rsp_q <= 1'b0;
      mal_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      exempt_q <= exempt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      mal_q <= mal_d;
    end
  end

  //------------------------------------------------------------
  // Link drive
  //------------------------------------------------------------
  // request low from wait through done, high again in release
  assign lnk.hold_request_n = ~((st_q == DCHBH_H_WAIT) || (st_q == DCHBH_H_XFER) || (st_q == DCHBH_H_DONE));
  // Strobes only during transfer
  assign lnk.host_rd_n = ~(((st_q == DCHBH_H_XFER) || (st_q == DCHBH_H_DONE)) && !wr_q);
  assign lnk.host_wr_n = ~((st_q == DCHBH_H_XFER) && wr_q);
  assign lnk.host_addr = addr_q;
  assign lnk.host_wdata = wdata_q;
  assign lnk.host_data_oe = (st_q == DCHBH_H_XFER) && wr_q;
  assign req_ready = (st_q == DCHBH_H_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign malfunction = mal_q;
endmodule : dchbh_host

/* File: core/dchbh_if.sv */
interface dchbh_if;
  import dchbh_pkg::*;
  // Handover handshake
  logic hold_request_n;
  logic hold_acknowledge_n;
  // Host memory strobes, active low
  logic host_rd_n;
  logic host_wr_n;
  // Host address
  dchbh_addr_t host_addr;
  // Host data, two-way
  dchbh_data_t host_wdata;
  logic host_data_oe;
  dchbh_data_t dev_rdata;
  logic dev_data_oe;
  // Resolved host data wire
  dchbh_data_t host_data;
  assign host_data = dev_data_oe ? dev_rdata : (host_data_oe ? host_wdata : '0);

  // Host end
  modport host (
    output hold_request_n, host_rd_n, host_wr_n, host_addr, host_wdata, host_data_oe,
    input hold_acknowledge_n, host_data
  );
  // Device end
  modport device (
    input hold_request_n, host_rd_n, host_wr_n, host_addr, host_data,
    output hold_acknowledge_n, dev_rdata, dev_data_oe
  );
endinterface : dchbh_if

/* File: core/dchbh_pkg.sv */
`include "dchbh_consts.svh"
package dchbh_pkg;
  // Address and data types
  typedef logic [`DCHBH_AW-1:0] dchbh_addr_t;
  typedef logic [`DCHBH_DW-1:0] dchbh_data_t;
  // Device states
  typedef enum logic [1:0] {DCHBH_RUN, DCHBH_FINISH, DCHBH_FLOAT, DCHBH_GRANT} dchbh_dev_st_t;
  // Host states
  typedef enum logic [2:0] {DCHBH_H_IDLE, DCHBH_H_WAIT, DCHBH_H_XFER, DCHBH_H_DONE, DCHBH_H_REL} dchbh_host_st_t;
endpackage : dchbh_pkg

/* File: testbench/dchbh_assertions.sv */
module dchbh_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Handover handshake
  input wire logic hold_request_n,
  input wire logic hold_acknowledge_n,
  // Strobes and data enables
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  //----------------------------------------
  // Common clocking
  //----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Processor still finishing its instruction
  sequence s_halting;
    hold_acknowledge_n [*2];
  endsequence
  // Host memory access in progress
  sequence s_strobe;
    !host_rd_n || !host_wr_n;
  endsequence
  //----------------------------------------
  // Handover checks
  //----------------------------------------
  // no acknowledge in the two clocks after request falls
  chk_halt_delay: assert property ($fell(hold_request_n) |-> s_halting)
    else $error("acknowledge came too early");
  chk_grant_latency: assert property ($fell(hold_acknowledge_n) |->
    !$past(hold_request_n, 3) && !$past(hold_request_n))
    else $error("acknowledge without held request");
  chk_grant_hold: assert property (!hold_request_n && !hold_acknowledge_n |=> !hold_acknowledge_n)
    else $error("acknowledge dropped early");
  chk_grant_drop: assert property ($rose(hold_request_n) |=> hold_acknowledge_n)
    else $error("acknowledge kept after release");
  chk_strobe_grant: assert property (s_strobe |-> !hold_acknowledge_n)
    else $error("strobe without acknowledge");
  chk_strobe_req: assert property (s_strobe |-> !hold_request_n)
    else $error("strobe after request release");
  chk_data_owner: assert property (dev_data_oe |-> !host_data_oe)
    else $error("host data driven twice");
  // read data only from granted bus
  chk_read_grant: assert property (dev_data_oe |-> !$past(hold_acknowledge_n))
    else $error("device drives data without grant");
endmodule : dchbh_assertions

/* File: testbench/test_dual_cpu_halt_bus_handover.sv */
module test_dual_cpu_halt_bus_handover
  import dchbh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TMO = 50; // Short timeout
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, tmo_exempt = 1'b0;
  dchbh_addr_t req_addr = 16'h0000;
  dchbh_data_t req_wdata = 8'h00;
  logic req_ready, rsp_valid, malfunction;
  dchbh_data_t rsp_rdata, rd;
  logic hold_inhibit = 1'b0, instr_done = 1'b1;
  logic cpu_rd_n = 1'b0; // Core keeps reading while it runs
  dchbh_addr_t cpu_addr = 16'h3C5A, mem_addr;
  dchbh_data_t cpu_wdata = 8'h96, mem_wdata, mem_rdata;
  logic cpu_stall, bus_granted, mem_rd_n, mem_wr_n, cpu_addr_oe;
  dchbh_data_t mem [0:255]; // Local memory
  int err_count = 0, n_checks = 0;
  // Clock and memory
  always #50 clk = ~clk;
  assign mem_rdata = mem[mem_addr[7:0]];
  always @(posedge clk) if (!mem_wr_n) mem[mem_addr[7:0]] <= mem_wdata;
  //----------------------------------------
  // Both ends and checker
  //----------------------------------------
  dchbh_if lnk();
  dchbh_host #(.TMO_CYC(TMO)) dchbh_host_i (.clk(clk), .rst_n(rst_n), .lnk(lnk), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .tmo_exempt(tmo_exempt), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .malfunction(malfunction));
  dchbh_device dchbh_device_i (.clk(clk), .rst_n(rst_n), .lnk(lnk), .hold_inhibit(hold_inhibit),
    .instr_done(instr_done), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rd_n(cpu_rd_n), .cpu_wr_n(1'b1),
    .cpu_stall(cpu_stall), .bus_granted(bus_granted), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .cpu_addr_oe(cpu_addr_oe), .mem_rdata(mem_rdata));
  dchbh_assertions dchbh_assertions_i (.clk(clk), .rst_n(rst_n), .hold_request_n(lnk.hold_request_n),
    .hold_acknowledge_n(lnk.hold_acknowledge_n), .host_rd_n(lnk.host_rd_n), .host_wr_n(lnk.host_wr_n),
    .host_data_oe(lnk.host_data_oe), .dev_data_oe(lnk.dev_data_oe));
  //----------------------------------------
  // Tasks
  //----------------------------------------
  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Hand one request to the host end
  task automatic start(input logic wr, input dchbh_addr_t a, input dchbh_data_t d, input logic ex);
    @(negedge clk);
    check("ready", req_ready, 1'b1);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    tmo_exempt <= ex;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : start
  // Wait for the answer, watching the grant
  task automatic finish(input logic wr, input dchbh_addr_t a, output dchbh_data_t q);
    bit seen;
    bit [1:0] stb;
    seen = 1'b0;
    stb = 2'b00;
    for (int n = 0; n < 200 && rsp_valid !== 1'b1; n++)
    begin
      @(negedge clk);
      if (bus_granted === 1'b1 && !seen)
      begin
        seen = 1'b1;
        check("halted", {cpu_stall, cpu_addr_oe, lnk.hold_acknowledge_n, mem_rd_n}, 4'b1001);
        check("mem addr", mem_addr, a);
      end
      if (bus_granted === 1'b1)
        stb = stb | {~mem_rd_n, ~mem_wr_n};
    end
    check("grant", seen, 1'b1);
    check("strobes", stb, wr ? 2'b01 : 2'b10);
    check("answer", rsp_valid, 1'b1);
    q = rsp_rdata;
    repeat (3) @(negedge clk);
    check("resumed", {bus_granted, cpu_stall, cpu_addr_oe, lnk.hold_acknowledge_n, mem_rd_n}, 5'b00110);
    check("cpu addr", mem_addr, cpu_addr);
    check("cpu data", mem_wdata, cpu_wdata);
  endtask : finish
  // Whole transfer
  task automatic xfer(input logic wr, input dchbh_addr_t a, input dchbh_data_t d, output dchbh_data_t q);
    start(wr, a, d, 1'b0);
    finish(wr, a, q);
  endtask : xfer
  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  //----------------------------------------
  // Scenarios
  //----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("reset", {lnk.hold_request_n, lnk.hold_acknowledge_n, bus_granted, malfunction}, 4'b1100);
    // Back-to-back writes then reads
    for (int i = 0; i < 4; i++) xfer(1'b1, dchbh_addr_t'(16'h0040 + i), 8'(8'hC3 ^ i), rd);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, dchbh_addr_t'(16'h0040 + i), 8'h00, rd);
      check("read", rd, 8'(8'hC3 ^ i));
    end
    // Instruction still running
    @(posedge clk) instr_done <= 1'b0;
    start(1'b0, 16'h0041, 8'h00, 1'b0);
    repeat (10) @(negedge clk);
    check("no early grant", {bus_granted, lnk.hold_acknowledge_n}, 2'b01);
    @(posedge clk) instr_done <= 1'b1;
    finish(1'b0, 16'h0041, rd);
    check("late read", rd, 8'hC2);
    // Inhibited, exempt from timeout
    @(posedge clk) hold_inhibit <= 1'b1;
    start(1'b1, 16'h0080, 8'h5A, 1'b1);
    repeat (TMO + 20) @(negedge clk);
    check("inhibit exempt", {bus_granted, malfunction}, 2'b00);
    @(posedge clk) hold_inhibit <= 1'b0;
    finish(1'b1, 16'h0080, rd);
    // Inhibited, timeout flags malfunction
    @(posedge clk) hold_inhibit <= 1'b1;
    start(1'b0, 16'h0080, 8'h00, 1'b0);
    repeat (TMO - 2) @(negedge clk);
    check("no early timeout", malfunction, 1'b0);
    repeat (22) @(negedge clk);
    check("timeout", {malfunction, lnk.hold_request_n, req_ready, bus_granted}, 4'b1110);
    // Request withdrawn while the instruction still runs
    @(posedge clk)
    begin
      hold_inhibit <= 1'b0;
      instr_done <= 1'b0;
    end
    start(1'b0, 16'h0080, 8'h00, 1'b0);
    repeat (TMO + 20) @(negedge clk);
    check("abort released", {lnk.hold_request_n, req_ready, bus_granted, cpu_stall}, 4'b1100);
    @(posedge clk) instr_done <= 1'b1;
    repeat (5) @(negedge clk);
    check("no stale grant", {bus_granted, cpu_stall, lnk.hold_acknowledge_n}, 3'b001);
    @(posedge clk) rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    hold_inhibit <= 1'b0;
    rst_n <= 1'b1;
    @(negedge clk);
    check("cleared", malfunction, 1'b0);
    xfer(1'b0, 16'h0080, 8'h00, rd);
    check("after reset", rd, 8'h5A);
    stop_test();
  end
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule : test_dual_cpu_halt_bus_handover
